// ### core/tp_link_monitor.v
// Per-port twisted-pair link supervision with register port
`timescale 1ns/1ns
`default_nettype none
`include "tp_link_map.vh"

module tp_link_monitor
#(
    parameter PORTS     = 4,
    parameter INHIBIT_C = `INHIBIT_MS * `CYC_PER_MS,
    parameter PD_C      = `PD_RESOLVE_MS * `CYC_PER_MS,
    parameter FLP_C     = `FLP_RESOLVE_MS * `CYC_PER_MS
)
(
    input  wire             clk_i,
    input  wire             rst_b_i,
    input  wire             aneg_strap_i,
    input  wire [PORTS-1:0] squelch_act_i,
    input  wire [PORTS-1:0] nlp_i,
    input  wire [PORTS-1:0] nlp_inv_i,
    input  wire [PORTS-1:0] flp_i,
    input  wire [PORTS-1:0] pkt_i,
    input  wire [PORTS-1:0] port_duplex_select_pin_i,
    input  wire [3:0]       addr_i,
    input  wire [15:0]      wdata_i,
    input  wire             wr_i,
    input  wire             rd_i,
    output reg  [15:0]      rdata_o,
    output reg  [PORTS-1:0] link_o,
    output reg  [PORTS-1:0] crs_o,
    output reg  [PORTS-1:0] full_duplex_o,
    output reg  [PORTS-1:0] pol_flip_o
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops each
    // Link and burst levels get a third flop for edge detection
    reg [PORTS-1:0] sq_m_r,  sq_r;
    reg [PORTS-1:0] nlp_m_r, nlp_r;
    reg [PORTS-1:0] inv_m_r, inv_r;
    reg [PORTS-1:0] flp_m_r, flp_r;
    reg [PORTS-1:0] pkt_m_r, pkt_r;
    reg [PORTS-1:0] fdx_m_r, fdx_r;
    reg [PORTS-1:0] nlp_d_r, flp_d_r;
    reg             strap_m_r, strap_r;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sq_m_r  <= {PORTS{1'b0}};
            sq_r    <= {PORTS{1'b0}};
            nlp_m_r <= {PORTS{1'b0}};
            nlp_r   <= {PORTS{1'b0}};
            inv_m_r <= {PORTS{1'b0}};
            inv_r   <= {PORTS{1'b0}};
            flp_m_r <= {PORTS{1'b0}};
            flp_r   <= {PORTS{1'b0}};
            pkt_m_r <= {PORTS{1'b0}};
            pkt_r   <= {PORTS{1'b0}};
            fdx_m_r <= {PORTS{1'b0}};
            fdx_r   <= {PORTS{1'b0}};
            nlp_d_r <= {PORTS{1'b0}};
            flp_d_r <= {PORTS{1'b0}};
            strap_m_r <= 1'b0;
            strap_r   <= 1'b0;
        end
        else
        begin
            sq_m_r  <= squelch_act_i;
            sq_r    <= sq_m_r;
            nlp_m_r <= nlp_i;
            nlp_r   <= nlp_m_r;
            inv_m_r <= nlp_inv_i;
            inv_r   <= inv_m_r;
            flp_m_r <= flp_i;
            flp_r   <= flp_m_r;
            pkt_m_r <= pkt_i;
            pkt_r   <= pkt_m_r;
            fdx_m_r <= port_duplex_select_pin_i;
            fdx_r   <= fdx_m_r;
            nlp_d_r <= nlp_r;
            flp_d_r <= flp_r;
            strap_m_r <= aneg_strap_i;
            strap_r   <= strap_m_r;
        end
    end

    // One-cycle pulse events from synchronised levels
    wire [PORTS-1:0] nlp_ev = nlp_r & ~nlp_d_r;
    wire [PORTS-1:0] flp_ev = flp_r & ~flp_d_r;

    ////////////////////////////////////////////////////////////////////
    // Strap capture once after reset release. The strap synchroniser
    // needs two edges to fill after reset, so a marker bit travels
    // beside it and the capture waits for the marker; capturing any
    // earlier would always read the synchroniser's reset value.
    reg strap_vld_m_r;
    reg strap_vld_r;
    reg strap_done_r;
    reg strap_aneg_r;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            strap_vld_m_r <= 1'b0;
            strap_vld_r   <= 1'b0;
            strap_done_r  <= 1'b0;
            strap_aneg_r  <= 1'b0;
        end
        else
        begin
            strap_vld_m_r <= 1'b1;
            strap_vld_r   <= strap_vld_m_r;
            if (strap_vld_r && !strap_done_r)
            begin
                strap_done_r <= 1'b1;
                strap_aneg_r <= strap_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control and duplex registers; reset here also clears hung ports
    // Software must quiet a port's transmit before moving its duplex
    reg [1:0]       ctrl_r;
    reg [PORTS-1:0] dup_reg_r;
    // Register bit or captured strap enables negotiation
    wire            aneg_en = ctrl_r[`CTRL_ANEG_BIT] | strap_aneg_r;
    wire            efdx    = ctrl_r[`CTRL_EFDX_BIT];

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_r    <= `CTRL_RESET;
            dup_reg_r <= {PORTS{1'b0}};
        end
        else if (wr_i)
        begin
            if (addr_i == `REG_CTRL)
                ctrl_r <= wdata_i[1:0];
            if (addr_i == `REG_DUPLEX)
                dup_reg_r <= wdata_i[PORTS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-port link state, negotiation and polarity
    wire [PORTS-1:0] inh_busy;
    wire [PORTS-1:0] inh_fail;
    wire [PORTS-1:0] pol_flip;
    reg  [PORTS-1:0] neg_r;
    reg  [PORTS-1:0] by_flp_r;
    reg  [PORTS-1:0] start_r;
    reg  [28:0]      res_cnt_r [0:PORTS-1];

    // A port goes through three phases with negotiation on: it waits for
    // a burst or a link pulse, counts the resolve time, then runs the
    // inhibit timer, during which a link pulse gives link. Expiry of the
    // timer leaves the port without link and ready to start over.
    // With negotiation off, the first squelched activity or link pulse
    // gives link, and link then holds until the next hard reset.
    genvar p;
    generate
        for (p = 0; p < PORTS; p = p + 1)
        begin : g_port
            // Negotiation resolve counter and link decision
            always @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    neg_r[p]     <= 1'b0;
                    by_flp_r[p]  <= 1'b0;
                    start_r[p]   <= 1'b0;
                    res_cnt_r[p] <= 29'h0;
                    link_o[p]    <= 1'b0;
                end
                else if (strap_done_r)                // Strap known
                begin
                    start_r[p] <= 1'b0;
                    if (!aneg_en)
                    begin
                        neg_r[p]  <= 1'b0;
                        // Squelched activity or link pulses give link
                        if (sq_r[p] | nlp_ev[p])
                            link_o[p] <= 1'b1;
                    end
                    else if (!neg_r[p] && !link_o[p] && !inh_busy[p])
                    begin
                        // Only pulses start negotiation
                        if (flp_ev[p] | nlp_ev[p])
                        begin
                            neg_r[p]     <= 1'b1;
                            by_flp_r[p]  <= flp_ev[p];
                            res_cnt_r[p] <= 29'h0;
                        end
                    end
                    else if (neg_r[p])
                    begin
                        if (res_cnt_r[p] == (by_flp_r[p] ? FLP_C[28:0] - 1'b1
                                                         : PD_C[28:0] - 1'b1))
                        begin
                            neg_r[p]   <= 1'b0;
                            start_r[p] <= 1'b1;
                        end
                        else
                            res_cnt_r[p] <= res_cnt_r[p] + 1'b1;
                    end
                    else if (inh_busy[p] && nlp_ev[p])
                        link_o[p] <= 1'b1;
                    if (inh_fail[p])
                        link_o[p] <= 1'b0;
                end
            end

            tp_inhibit_timer
            #(
                .LIMIT (INHIBIT_C),
                .W     (27)
            )
            u_inhibit
            (
                .clk_i     (clk_i),
                .rst_b_i   (rst_b_i),
                .start_i   (start_r[p]),
                .link_ok_i (nlp_ev[p]),
                .busy_o    (inh_busy[p]),
                .fail_o    (inh_fail[p])
            );

            tp_pol_detect
            #(
                .CNT_W (3)
            )
            u_pol
            (
                .clk_i       (clk_i),
                .rst_b_i     (rst_b_i),
                .pulse_i     (nlp_ev[p]),
                .pulse_inv_i (inv_r[p]),
                .pkt_i       (pkt_r[p]),
                .pol_flip_o  (pol_flip[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Carrier sense, duplex and polarity outputs
    // Carrier sense follows squelched activity only on a port with link;
    // the hard reset clears it along with every other port output
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            crs_o         <= {PORTS{1'b0}};
            full_duplex_o <= {PORTS{1'b0}};
            pol_flip_o    <= {PORTS{1'b0}};
        end
        else
        begin
            crs_o         <= sq_r & link_o;
            full_duplex_o <= efdx ? fdx_r : dup_reg_r;
            pol_flip_o    <= pol_flip;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read, data in the cycle after the strobe
    // Unmapped addresses and idle cycles read as zero
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                `REG_CTRL:     rdata_o <= {14'h0000, ctrl_r};
                `REG_DUPLEX:   rdata_o <= {{(16-PORTS){1'b0}}, dup_reg_r};
                `REG_STATUS:   rdata_o <= {{(16-2*PORTS){1'b0}},
                                           full_duplex_o, link_o};
                `REG_POLARITY: rdata_o <= {{(16-PORTS){1'b0}}, pol_flip_o};
                default:       rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

endmodule // tp_link_monitor
`default_nettype wire

// ### core/tp_link_map.vh
// Constants for the twisted-pair link supervision block
`ifndef TP_LINK_MAP_VH
`define TP_LINK_MAP_VH

// Register indices on the plain register port
`define REG_CTRL          4'h0
`define REG_DUPLEX        4'h1
`define REG_STATUS        4'h2
`define REG_POLARITY      4'h3

// Control register fields
`define CTRL_ANEG_BIT     0
`define CTRL_EFDX_BIT     1

// Reset values
`define CTRL_RESET        2'h0
`define DUPLEX_RESET      4'h0

// Inhibit timer and resolve times in milliseconds
`define INHIBIT_MS        650
`define STD_INHIBIT_MS    750
`define PD_RESOLVE_MS     250
`define FLP_RESOLVE_MS    440

// Clock rate and cycles per millisecond
`define CLK_MHZ           100
`define CYC_PER_MS        (`CLK_MHZ * 1000)

// Consecutive inverted link pulses needed to flip polarity
`define POL_PULSES        7

`endif

// ### core/tp_pol_detect.v
// Receive polarity detector and corrector for one port
`timescale 1ns/1ns
`default_nettype none
`include "tp_link_map.vh"

module tp_pol_detect
#(
    parameter CNT_W = 3
)
(
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire pulse_i,
    input  wire pulse_inv_i,
    input  wire pkt_i,
    output reg  pol_flip_o
);

    reg [CNT_W-1:0] inv_cnt_r;

    ////////////////////////////////////////////////////////////////////
    // Count inverted link pulses; data packets break the run
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            inv_cnt_r  <= {CNT_W{1'b0}};
            pol_flip_o <= 1'b0;
        end
        else if (pkt_i)
        begin
            inv_cnt_r <= {CNT_W{1'b0}};
        end
        else if (pulse_i)
        begin
            if (pulse_inv_i == pol_flip_o)        // Pulse seems correct
                inv_cnt_r <= {CNT_W{1'b0}};
            else if (inv_cnt_r == `POL_PULSES - 1)
            begin
                pol_flip_o <= ~pol_flip_o;
                inv_cnt_r  <= {CNT_W{1'b0}};
            end
            else
                inv_cnt_r <= inv_cnt_r + 1'b1;
        end
    end

endmodule // tp_pol_detect
`default_nettype wire

// ### core/tp_inhibit_timer.v
// Link fail inhibit timer for one port
`timescale 1ns/1ns
`default_nettype none
`include "tp_link_map.vh"

module tp_inhibit_timer
#(
    parameter LIMIT = `INHIBIT_MS * `CYC_PER_MS,
    parameter W     = 27
)
(
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire start_i,
    input  wire link_ok_i,
    output reg  busy_o,
    output reg  fail_o
);

    reg [W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////
    // Run from start until link forms or the limit expires
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_r  <= {W{1'b0}};
            busy_o <= 1'b0;
            fail_o <= 1'b0;
        end
        else
        begin
            fail_o <= 1'b0;
            if (start_i)
            begin
                busy_o <= 1'b1;
                cnt_r  <= {W{1'b0}};
            end
            else if (busy_o)
            begin
                if (link_ok_i)
                    busy_o <= 1'b0;
                else if (cnt_r == LIMIT[W-1:0] - 1'b1)
                begin
                    busy_o <= 1'b0;
                    fail_o <= 1'b1;
                end
                else
                    cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule // tp_inhibit_timer
`default_nettype wire

// ### verif/remote_link_partner.sv
// Remote link partner model driving the receive side of four ports
`timescale 1ns/1ns
`default_nettype none
module remote_link_partner
(
    input  wire logic       clk_i,
    output var  logic [3:0] sq_o,
    output var  logic [3:0] nlp_o,
    output var  logic [3:0] inv_o,
    output var  logic [3:0] flp_o,
    output var  logic [3:0] pkt_o
);
    // Quiet cable at time zero
    initial
    begin
        sq_o  = 4'h0;
        nlp_o = 4'h0;
        inv_o = 4'h0;
        flp_o = 4'h0;
        pkt_o = 4'h0;
    end

    // Pulse of kind k (0 link, 1 burst, 2 packet) held two cycles
    task automatic pulse(input int k, input int p, input logic v);
        @(posedge clk_i);
        nlp_o[p] <= (k == 0);
        flp_o[p] <= (k == 1);
        pkt_o[p] <= (k == 2);
        inv_o[p] <= v;
        repeat (2) @(posedge clk_i);
        nlp_o[p] <= 1'b0;
        flp_o[p] <= 1'b0;
        pkt_o[p] <= 1'b0;
        inv_o[p] <= ~v;  // Polarity is meaningless between pulses
        repeat (3) @(posedge clk_i);
    endtask

    // Receive activity passing squelch
    task automatic set_sq(input int p, input logic v);
        @(posedge clk_i);
        sq_o[p] <= v;
    endtask
endmodule // remote_link_partner
`default_nettype wire

// ### verif/tp_link_monitor_props.sv
// Port-level assertions for the link supervision block
`timescale 1ns/1ns
`default_nettype none
`include "tp_link_map.vh"
module tp_link_monitor_props
#(
    parameter PORTS = 4
)
(
    input wire logic             clk_i,
    input wire logic             rst_b_i,
    input wire logic             aneg_strap_i,
    input wire logic [PORTS-1:0] squelch_act_i,
    input wire logic [PORTS-1:0] nlp_i,
    input wire logic [PORTS-1:0] nlp_inv_i,
    input wire logic [PORTS-1:0] flp_i,
    input wire logic [PORTS-1:0] pkt_i,
    input wire logic [PORTS-1:0] port_duplex_select_pin_i,
    input wire logic [3:0]       addr_i,
    input wire logic [15:0]      wdata_i,
    input wire logic             wr_i,
    input wire logic             rd_i,
    input wire logic [15:0]      rdata_o,
    input wire logic [PORTS-1:0] link_o,
    input wire logic [PORTS-1:0] crs_o,
    input wire logic [PORTS-1:0] full_duplex_o,
    input wire logic [PORTS-1:0] pol_flip_o
);
    logic [1:0]       ctrl_r;
    logic [PORTS-1:0] dup_r;
    logic [3:0]       age_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Shadow of control and duplex writes, age of the last link pulse
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_r <= 2'h0;
            dup_r  <= '0;
            age_r  <= 4'hf;
        end
        else
        begin
            if (wr_i && addr_i == `REG_CTRL)
                ctrl_r <= wdata_i[1:0];
            if (wr_i && addr_i == `REG_DUPLEX)
                dup_r <= wdata_i[PORTS-1:0];
            if (|nlp_i)
                age_r <= 4'h0;
            else if (age_r != 4'hf)
                age_r <= age_r + 4'h1;
        end
    end
    ////////////////////////////////////////
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 16'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("Stray read data");
    property p_unmapped;
        $past(rd_i) && $past(addr_i) > 4'h3 |-> rdata_o == 16'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read");
    property p_status;
        $past(rd_i) && $past(addr_i) == `REG_STATUS |->
            rdata_o == {8'h0, $past(full_duplex_o), $past(link_o)};
    endproperty
    a_status: assert property (p_status) else $error("Status read wrong");
    property p_crs_link;
        (crs_o & ~(link_o | $past(link_o))) == '0;
    endproperty
    a_crs_link: assert property (p_crs_link)
        else $error("Carrier sense without link");
    property p_aneg_sq;
        (link_o & ~$past(link_o)) != '0 && age_r > 4'h8 |->
            !ctrl_r[0] && !aneg_strap_i;
    endproperty
    a_aneg_sq: assert property (p_aneg_sq)
        else $error("Link from activity with negotiation on");
    property p_sticky;
        !ctrl_r[0] && !$past(ctrl_r[0]) && !aneg_strap_i |->
            (link_o & $past(link_o)) == $past(link_o);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Link dropped without negotiation");
    property p_pol_nlp;
        pol_flip_o != $past(pol_flip_o) |-> age_r < 4'h8;
    endproperty
    a_pol_nlp: assert property (p_pol_nlp)
        else $error("Polarity moved without link pulse");
    property p_fd_reg;
        !ctrl_r[1] && !$past(wr_i) && !$past(wr_i, 2) |->
            full_duplex_o == dup_r;
    endproperty
    a_fd_reg: assert property (p_fd_reg)
        else $error("Duplex differs from register");
endmodule // tp_link_monitor_props

bind tp_link_monitor tp_link_monitor_props #(.PORTS(PORTS)) u_props
(
    .clk_i(clk_i), .rst_b_i(rst_b_i), .aneg_strap_i(aneg_strap_i),
    .squelch_act_i(squelch_act_i), .nlp_i(nlp_i), .nlp_inv_i(nlp_inv_i),
    .flp_i(flp_i), .pkt_i(pkt_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .port_duplex_select_pin_i(port_duplex_select_pin_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .link_o(link_o), .crs_o(crs_o),
    .full_duplex_o(full_duplex_o), .pol_flip_o(pol_flip_o)
);
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench with a reference model of the link supervision block
`timescale 1ns/1ns
`default_nettype none
`include "tp_link_map.vh"
module tb;
    localparam int IC = 50;
    localparam int PC = 20;
    localparam int FC = 30;
    logic        clk_i   = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        strap   = 1'b0;
    logic [3:0]  pin     = 4'h0;
    logic [3:0]  addr    = 4'h0;
    logic [15:0] wdata   = 16'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [31:0] rnd     = 32'h21f4;
    logic [3:0]  e_dup   = 4'h0;
    logic [3:0]  e_link  = 4'h0;
    logic [3:0]  e_pol   = 4'h0;
    logic [15:0] got;
    int          run [4] = '{default: 0};
    int          err_count = 0;
    int          check_count = 0;
    wire  [3:0]  sq, nlp, inv, flp, pkt, link, crs, fdx, pol;
    wire  [15:0] rdata;

    always #5 clk_i = ~clk_i;
    remote_link_partner P (.clk_i(clk_i), .sq_o(sq), .nlp_o(nlp),
        .inv_o(inv), .flp_o(flp), .pkt_o(pkt));
    tp_link_monitor #(.PORTS(4), .INHIBIT_C(IC), .PD_C(PC), .FLP_C(FC)) DUT
    (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .aneg_strap_i(strap),
        .squelch_act_i(sq), .nlp_i(nlp), .nlp_inv_i(inv), .flp_i(flp),
        .pkt_i(pkt), .port_duplex_select_pin_i(pin), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .link_o(link), .crs_o(crs), .full_duplex_o(fdx), .pol_flip_o(pol)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Wait n edges, then let the outputs settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask
    // Read one register and compare with the model
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1 got = rdata;
        check_count++;
        if (got !== e)
        begin
            err_count++;
            $display("unexpected read at %0t: %h, model %h", $time, got, e);
        end
    endtask
    // Compare masked port outputs with the model
    task automatic chk_port(input logic [3:0] g, e, m);
        check_count++;
        if ((g & m) !== (e & m))
        begin
            err_count++;
            $display("unexpected port at %0t: %h, model %h", $time, g, e);
        end
    endtask
    // Link pulse plus the model's inverted-pulse run
    task automatic send_nlp(input int p, input logic v);
        P.pulse(0, p, v);
        run[p] = (v != e_pol[p]) ? run[p] + 1 : 0;
        if (run[p] == `POL_PULSES)
        begin
            e_pol[p] = ~e_pol[p];
            run[p] = 0;
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Cut a hang short at several times the expected run
    initial
    begin
        #60000;
        err_count++;
        final_report();
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        cyc(1);
        chk_port(link | crs | fdx | pol, 4'h0, 4'hf);
        rd_chk(`REG_CTRL, {14'h0, `CTRL_RESET});
        rd_chk(`REG_DUPLEX, {12'h0, `DUPLEX_RESET});
        wr_reg(4'h9, 16'hffff);
        rd_chk(4'h9, 16'h0);
        rd_chk(`REG_CTRL, 16'h0);
        $display("test registers done");
        rnd = xs(rnd);
        e_dup = rnd[3:0];
        wr_reg(`REG_DUPLEX, {12'h0, e_dup});
        rd_chk(`REG_DUPLEX, {12'h0, e_dup});
        cyc(4);
        chk_port(fdx, e_dup, 4'hf);
        @(posedge clk_i);
        pin <= ~e_dup;
        wr_reg(`REG_CTRL, 16'h2);
        cyc(8);
        chk_port(fdx, ~e_dup, 4'hf);
        wr_reg(`REG_CTRL, 16'h0);
        cyc(4);
        chk_port(fdx, e_dup, 4'hf);
        $display("test duplex done");
        P.set_sq(0, 1'b1);
        cyc(8);
        e_link[0] = 1'b1;
        chk_port(link, e_link, 4'hf);
        chk_port(crs, 4'h1, 4'hf);
        rd_chk(`REG_STATUS, {8'h0, e_dup, e_link});
        P.set_sq(0, 1'b0);
        cyc(8);
        chk_port(crs | link, e_link, 4'hf);
        $display("test activity link done");
        repeat (6) send_nlp(1, 1'b1);
        P.pulse(2, 1, 1'b0);
        run[1] = 0;
        repeat (6) send_nlp(1, 1'b1);
        cyc(8);
        chk_port(pol, e_pol, 4'hf);
        send_nlp(1, 1'b1);
        cyc(8);
        e_link[1] = 1'b1;
        chk_port(pol, e_pol, 4'hf);
        rd_chk(`REG_POLARITY, {12'h0, e_pol});
        $display("test polarity done");
        wr_reg(`REG_CTRL, 16'h1);
        P.set_sq(2, 1'b1);
        cyc(FC + IC + 20);
        chk_port(link, e_link, 4'h4);
        P.set_sq(2, 1'b0);
        P.pulse(1, 2, 1'b0);
        cyc(FC + 10);
        send_nlp(2, 1'b0);
        send_nlp(3, 1'b0);
        cyc(PC + 5);
        send_nlp(3, 1'b0);
        cyc(8);
        e_link[3:2] = 2'h3;
        chk_port(link, e_link, 4'hc);
        $display("test negotiation done");
        P.set_sq(0, 1'b1);
        cyc(6);
        chk_port(crs, 4'h1, 4'h1);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        strap   <= 1'b1;
        cyc(10);
        chk_port(link | crs | fdx | pol, 4'h0, 4'hf);
        e_link = 4'h0;
        e_pol  = 4'h0;
        run    = '{default: 0};
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        P.set_sq(3, 1'b1);
        cyc(FC + IC + 20);
        chk_port(link, e_link, 4'h9);
        chk_port(crs, 4'h0, 4'h9);
        rd_chk(`REG_CTRL, 16'h0);
        P.pulse(1, 1, 1'b0);
        cyc(FC + IC + 30);
        send_nlp(1, 1'b0);
        cyc(4);
        chk_port(link, 4'h0, 4'h2);
        $display("test reset and strap done");
        final_report();
    end
endmodule // tb
`default_nettype wire
